// ---- hw/twu_timer_watchdog.sv ----
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module twu_timer_watchdog
  import twu_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_input_pin,
  input  wire logic        hw_watchdog_strap,
  output logic             waveform_output_pin,
  output logic             eoc_irq,
  output logic             sys_reset_req
);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  twu_ctrl_t   ctrl_r;
  logic [15:0] const_r;
  logic [15:0] cnt_r;
  logic [7:0]  psc_r;
  logic [7:0]  psc_cnt_r;
  logic [1:0]  div_r;
  logic        const_new_r;
  logic        trig_r;
  logic        key_armed_r;
  logic        wdg_sw_r;
  logic        hw_wdg_r;
  logic        strap_done_r;
  logic        pin_r;
  logic        irq_r;
  logic        rst_req_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  logic        fall;
  logic        tick4;
  logic        src_tick;
  logic        cnt_tick;
  logic        eoc;
  logic        wdg_on;
  logic        retrig;
  logic        key_reload;
  logic        start;
  logic        wr;
  logic        wr_hi;
  logic        wr_lo;
  logic        wr_psc;
  logic        wr_ctrl;
  logic        wr_wdg;
  logic [7:0]  wdata;
  logic        mapped;

  twu_fall_detect u_fall
  (
    .core_clk (core_clk),
    .reset    (reset),
    .level    (count_input_pin),
    .fall     (fall)
  );

  // ----------------------------------------------------------------
  // apb slave: setup then one access cycle, no wait states
  // ----------------------------------------------------------------
  assign wr      = psel & penable & pready_r & pwrite;
  assign wdata   = pwdata[7:0];
  assign wr_hi   = wr & (paddr == TWU_OFF_CNT_HI);
  assign wr_lo   = wr & (paddr == TWU_OFF_CNT_LO);
  assign wr_psc  = wr & (paddr == TWU_OFF_PSC);
  assign wr_ctrl = wr & (paddr == TWU_OFF_CTRL);
  assign wr_wdg  = wr & (paddr == TWU_OFF_WDG);
  assign mapped  = (paddr == TWU_OFF_CNT_HI) | (paddr == TWU_OFF_CNT_LO) |
                   (paddr == TWU_OFF_PSC) | (paddr == TWU_OFF_CTRL) |
                   (paddr == TWU_OFF_WDG) | (paddr == TWU_OFF_STAT);

  // answer is prepared in the setup cycle so every output is a flop
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~mapped;
      prdata_r  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite)
      begin
        case (paddr)
          // counter reads return the live value
          TWU_OFF_CNT_HI: prdata_r[7:0] <= cnt_r[15:8];
          TWU_OFF_CNT_LO: prdata_r[7:0] <= cnt_r[7:0];
          TWU_OFF_PSC:    prdata_r[7:0] <= psc_r;
          TWU_OFF_CTRL:   prdata_r[7:0] <= ctrl_r;
          TWU_OFF_WDG:    prdata_r[7:0] <= {1'b0, ~wdg_sw_r, TWU_WDG_FILL[5:0]};
          TWU_OFF_STAT:   prdata_r[2:0] <= {wdg_on, hw_wdg_r, pin_r};
          default:        prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // watchdog enables
  // ----------------------------------------------------------------
  // strap is caught once after reset release, never by the reset itself
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      strap_done_r <= 1'b0;
      hw_wdg_r     <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      hw_wdg_r     <= ~hw_watchdog_strap;
    end
  end

  // software enable is sticky: only a reset clears it
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      wdg_sw_r <= 1'b0;
    else if (wr_wdg & ~pwdata[TWU_WDG_EN_BIT] & ~hw_wdg_r)
      wdg_sw_r <= 1'b1;
  end

  assign wdg_on = wdg_sw_r | hw_wdg_r;

  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  // free running divide by four of the internal clock
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end

  assign tick4 = (div_r == TWU_DIV_LAST);

  // triggerable mode waits for a falling edge after run is set
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      trig_r <= 1'b0;
    else if (!ctrl_r.run_bit)
      trig_r <= 1'b0;
    else if (fall & ctrl_r.input_enable_bit &
             (ctrl_r.input_mode_field == TWU_IN_TRIG))
      trig_r <= 1'b1;
  end

  // watchdog ignores run, mode and input bits and always runs on clk/4
  always_comb
  begin
    src_tick = 1'b0;
    if (wdg_on)
      src_tick = tick4;
    else if (!ctrl_r.run_bit)
      src_tick = 1'b0;
    else if (!ctrl_r.input_enable_bit)
      src_tick = tick4;
    else
    begin
      case (ctrl_r.input_mode_field)
        TWU_IN_EVENT:  src_tick = fall;
        TWU_IN_GATED:  src_tick = tick4 & count_input_pin;
        TWU_IN_TRIG:   src_tick = tick4 & trig_r;
        TWU_IN_RETRIG: src_tick = tick4;
        default:       src_tick = 1'b0;
      endcase
    end
  end

  assign retrig = ~wdg_on & ctrl_r.run_bit & ctrl_r.input_enable_bit &
                  (ctrl_r.input_mode_field == TWU_IN_RETRIG) & fall;
  assign key_reload = wdg_on & wr_lo & key_armed_r &
                      (wdata == TWU_KEY_SECOND);
  assign start = ~wdg_on & wr_ctrl & pwdata[7] & ~ctrl_r.run_bit;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // compare against the live register so a new value acts at once
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      psc_cnt_r <= 8'h00;
    else if (retrig | key_reload)
      psc_cnt_r <= 8'h00;
    else if (src_tick)
      psc_cnt_r <= (psc_cnt_r >= psc_r) ? 8'h00 : psc_cnt_r + 8'h01;
  end

  assign cnt_tick = src_tick & (psc_cnt_r >= psc_r);
  assign eoc      = cnt_tick & (cnt_r == 16'h0000);

  // prescaler stays writable even in watchdog mode
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      psc_r <= TWU_RST_BYTE;
    else if (wr_psc)
      psc_r <= wdata;
  end

  // ----------------------------------------------------------------
  // constant and counter
  // ----------------------------------------------------------------
  // constant frozen in watchdog mode; hardware mode keeps FFFFh
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      const_r <= TWU_HW_CONST;
    else if (!wdg_on)
    begin
      if (wr_hi)
        const_r[15:8] <= wdata;
      if (wr_lo)
        const_r[7:0] <= wdata;
    end
  end

  // a write in the same cycle as a load keeps the flag set
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      const_new_r <= 1'b0;
    else if (~wdg_on & (wr_hi | wr_lo))
      const_new_r <= 1'b1;
    else if (eoc | retrig | start)
      const_new_r <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      cnt_r <= TWU_HW_CONST;
    else if (key_reload | retrig)
      cnt_r <= const_r;
    else if (start & const_new_r)
      cnt_r <= const_r;
    else if (eoc)
      cnt_r <= const_r;
    else if (cnt_tick)
      cnt_r <= cnt_r - 16'h0001;
  end

  // refresh key: any low byte write other than the first key disarms
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      key_armed_r <= 1'b0;
    else if (wr_lo)
      key_armed_r <= (wdata == TWU_KEY_FIRST);
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // software write wins over the single mode clear of run
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      ctrl_r <= twu_ctrl_t'(TWU_RST_CTRL);
    else if (wr_ctrl)
      ctrl_r <= twu_ctrl_t'(wdata);
    else if (eoc & ~wdg_on & ctrl_r.single)
      ctrl_r.run_bit <= 1'b0;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pin idles high so other alternate functions can share it
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      pin_r <= 1'b1;
    else if (!ctrl_r.output_enable_bit)
      pin_r <= 1'b1;
    else if (eoc & ~wdg_on)
      pin_r <= ctrl_r.output_mode_bit ? ctrl_r.output_level_bit
                                      : ~pin_r;
  end

  // one pulse per end of count; routing lies outside this block
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_r     <= 1'b0;
      rst_req_r <= 1'b0;
    end
    else
    begin
      irq_r     <= eoc & ~wdg_on;
      rst_req_r <= eoc & wdg_on;
    end
  end

  assign waveform_output_pin = pin_r;
  assign eoc_irq             = irq_r;
  assign sys_reset_req       = rst_req_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_div_four: assert property (tick4 |=> !tick4 [*3] ##1 tick4)
    else $error("divide by four tick spacing wrong");

  a_stop_halts: assert property
    (!wdg_on && !ctrl_r.run_bit && !retrig && !start |=> cnt_r == $past(cnt_r))
    else $error("counter moved while stopped");

  a_eoc_reload: assert property
    (eoc && !key_reload && !retrig |=> cnt_r == $past(const_r))
    else $error("end of count did not reload constant");

  a_single_stop: assert property
    (eoc && !wdg_on && ctrl_r.single && !wr_ctrl |=> !ctrl_r.run_bit)
    else $error("single mode did not clear run");

  a_pin_idle_high: assert property
    (!ctrl_r.output_enable_bit |=> waveform_output_pin)
    else $error("disabled output not high");

  a_square_toggle: assert property
    (eoc && !wdg_on && ctrl_r.output_enable_bit && !ctrl_r.output_mode_bit
     |=> waveform_output_pin != $past(waveform_output_pin))
    else $error("square wave did not toggle");

  a_pwm_copy: assert property
    (eoc && !wdg_on && ctrl_r.output_enable_bit && ctrl_r.output_mode_bit
     |=> waveform_output_pin == $past(ctrl_r.output_level_bit))
    else $error("pwm level not copied");

  a_irq_pulse: assert property
    (eoc_irq |=> !eoc_irq)
    else $error("interrupt longer than one cycle");

  a_wdg_reset: assert property
    (eoc && wdg_on |=> sys_reset_req && !eoc_irq)
    else $error("watchdog end of count gave no reset");

  a_wdg_sticky: assert property
    (wdg_sw_r |=> wdg_sw_r)
    else $error("watchdog enable cleared by software");

  a_hw_const: assert property
    (hw_wdg_r |-> const_r == TWU_HW_CONST)
    else $error("hardware watchdog constant changed");

  a_key_reload: assert property
    (key_reload ##1 !key_reload |-> cnt_r == $past(const_r) && psc_cnt_r == 8'h00)
    else $error("refresh key did not restart count");

endmodule : twu_timer_watchdog

// ---- hw/twu_pkg.sv ----
package twu_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] TWU_OFF_CNT_HI = 8'h00;
  localparam logic [7:0] TWU_OFF_CNT_LO = 8'h04;
  localparam logic [7:0] TWU_OFF_PSC    = 8'h08;
  localparam logic [7:0] TWU_OFF_CTRL   = 8'h0C;
  localparam logic [7:0] TWU_OFF_WDG    = 8'h10;
  localparam logic [7:0] TWU_OFF_STAT   = 8'h14;

  // ----------------------------------------------------------------
  // reset values and fixed constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  TWU_RST_CTRL  = 8'h12;
  localparam logic [7:0]  TWU_RST_BYTE  = 8'hFF;
  localparam logic [15:0] TWU_HW_CONST  = 16'hFFFF;
  localparam logic [7:0]  TWU_KEY_FIRST = 8'hAA;
  localparam logic [7:0]  TWU_KEY_SECOND = 8'h55;
  localparam int          TWU_WDG_EN_BIT = 6;
  localparam logic [7:0]  TWU_WDG_FILL  = 8'h3F;

  // internal clock divider for the timer tick
  localparam int          TWU_DIV       = 4;
  localparam logic [1:0]  TWU_DIV_LAST  = 2'(TWU_DIV - 1);

  // input mode field codes
  localparam logic [1:0] TWU_IN_EVENT  = 2'h0;
  localparam logic [1:0] TWU_IN_GATED  = 2'h1;
  localparam logic [1:0] TWU_IN_TRIG   = 2'h2;
  localparam logic [1:0] TWU_IN_RETRIG = 2'h3;

  // timer_control_reg layout, bit 7 down to bit 0
  typedef struct packed {
    logic       run_bit;
    logic       single;
    logic [1:0] input_mode_field;
    logic       input_enable_bit;
    logic       output_mode_bit;
    logic       output_level_bit;
    logic       output_enable_bit;
  } twu_ctrl_t;

endpackage : twu_pkg

// ---- hw/twu_fall_detect.sv ----
`timescale 1ns/1ns
// falling edge detector for a pin already synchronous to the clock
module twu_fall_detect
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic level,
  output logic      fall
);

  logic prev_r;

  // reset low: a fall needs a high seen first, so no false edge after reset
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      prev_r <= 1'b0;
    else
      prev_r <= level;
  end

  assign fall = prev_r & ~level;

endmodule : twu_fall_detect

// ---- bench/twu_pin_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// count input source standing in for the outside world
// ----------------------------------------------------------------
module twu_pin_model
(
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [3:0] n_falls,
  input  wire logic       idle_lvl,
  output logic            pin,
  output logic            busy
);
  localparam int GAP = 8;

  // a burst of falls, each a high then a low phase; between bursts the
  // pin rests at the level the bench asks for, so gated runs stay legal
  initial
  begin
    pin  = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge core_clk);
      if (go)
      begin
        busy <= 1'b1;
        repeat (n_falls)
        begin
          pin <= 1'b1;
          repeat (GAP / 2) @(posedge core_clk);
          pin <= 1'b0;
          repeat (GAP / 2) @(posedge core_clk);
        end
        busy <= 1'b0;
      end
      else
      begin
        pin <= idle_lvl;
      end
    end
  end
endmodule : twu_pin_model

// ---- bench/twu_timer_watchdog_tb_top.sv ----
`timescale 1ns/1ns
module twu_timer_watchdog_tb_top;
  import twu_pkg::*;
  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic        strap, go, idle_lvl, pin, busy, eoc_irq, sys_reset_req;
  logic        waveform_output_pin, err, p0;
  logic [7:0]  paddr;
  logic [3:0]  n_falls;
  logic [31:0] pwdata, prdata, rd, p;
  int          fails, n_compared, n_eoc, n_sys, n, c;

  twu_timer_watchdog i_twu_timer_watchdog (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_input_pin(pin),
    .hw_watchdog_strap(strap), .waveform_output_pin(waveform_output_pin),
    .eoc_irq(eoc_irq), .sys_reset_req(sys_reset_req));

  twu_pin_model i_twu_pin_model (
    .core_clk(core_clk), .go(go), .n_falls(n_falls),
    .idle_lvl(idle_lvl), .pin(pin), .busy(busy));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; the request stands until pready is seen high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input string nm);
    xfer(a, 1'b0, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask : rd_chk

  task automatic idle(input int k);
    repeat (k) @(posedge core_clk);
  endtask : idle

  // cycles until the next pulse; a miss shows as a count of 2000
  task automatic wait_ev(input bit sys, output int k);
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (!(sys ? sys_reset_req === 1'b1 : eoc_irq === 1'b1) && k < 2000);
  endtask : wait_ev

  task automatic fire(input logic [3:0] k);
    int w;
    go      <= 1'b1;
    n_falls <= k;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    w = 0;
    while (busy === 1'b1 && w < 300)
    begin
      @(posedge core_clk);
      w++;
    end
  endtask : fire

  // ----------------------------------------------------------------
  // clock, pulse tallies, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // tallies let quiet spans be checked without polling each cycle
  always @(posedge core_clk)
  begin
    if (eoc_irq === 1'b1) n_eoc++;
    if (sys_reset_req === 1'b1) n_sys++;
  end

  // whole run is around a thousand cycles; this margin only cuts a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap = 1'b1;
    go = 1'b0;
    idle_lvl = 1'b0;
    n_falls = 4'h0;
    idle(3);
    reset <= 1'b0;
    idle(2);
    // reset values and an unmapped place
    rd_chk(TWU_OFF_CTRL, 8'h12, "ctrl_rst");
    rd_chk(TWU_OFF_PSC, 8'hFF, "psc_rst");
    rd_chk(TWU_OFF_CNT_HI, 8'hFF, "cnt_rst");
    rd_chk(TWU_OFF_WDG, 8'h7F, "wdg_rst");
    chk("pin_off", 1, waveform_output_pin);
    xfer(8'h18, 1'b0, 8'h00);
    chk("unmapped_err", 1, err);
    // continuous, internal clock over four, square wave then pwm
    wr(TWU_OFF_CNT_HI, 8'h00);
    wr(TWU_OFF_CNT_LO, 8'h03);
    wr(TWU_OFF_PSC, 8'h00);
    wr(TWU_OFF_CTRL, 8'h81);
    wait_ev(0, n);
    wait_ev(0, n);
    chk("period_n3_p0", 16, n);
    @(posedge core_clk);
    chk("irq_width", 0, eoc_irq);
    p0 = waveform_output_pin;
    wait_ev(0, n);
    idle(2);
    chk("square", {31'h0, ~p0}, waveform_output_pin);
    wr(TWU_OFF_PSC, 8'h01);
    wait_ev(0, n);
    wait_ev(0, n);
    chk("period_p1", 32, n);
    wr(TWU_OFF_CNT_LO, 8'h01);
    wait_ev(0, n);
    wait_ev(0, n);
    chk("period_n1", 16, n);
    wr(TWU_OFF_CTRL, 8'h85);
    wait_ev(0, n);
    idle(2);
    chk("pwm_low", 0, waveform_output_pin);
    wr(TWU_OFF_CTRL, 8'h87);
    wait_ev(0, n);
    idle(2);
    chk("pwm_high", 1, waveform_output_pin);
    // stop holds the count, restart resumes it
    wr(TWU_OFF_CTRL, 8'h00);
    wr(TWU_OFF_CNT_HI, 8'h01);
    wr(TWU_OFF_CNT_LO, 8'h00);
    wr(TWU_OFF_CTRL, 8'h80);
    idle(40);
    wr(TWU_OFF_CTRL, 8'h00);
    xfer(TWU_OFF_CNT_LO, 1'b0, 8'h00);
    p = rd;
    idle(20);
    rd_chk(TWU_OFF_CNT_LO, p[7:0], "stop_hold");
    wr(TWU_OFF_CTRL, 8'h80);
    idle(20);
    rd_chk(TWU_OFF_CNT_HI, 8'h00, "resume");
    // single mode, run and mode in one write
    wr(TWU_OFF_CTRL, 8'h00);
    wr(TWU_OFF_CNT_HI, 8'h00);
    wr(TWU_OFF_CNT_LO, 8'h02);
    wr(TWU_OFF_PSC, 8'h00);
    wr(TWU_OFF_CTRL, 8'hC0);
    wait_ev(0, n);
    idle(2);
    rd_chk(TWU_OFF_CTRL, 8'h40, "single_stop");
    rd_chk(TWU_OFF_CNT_LO, 8'h02, "single_reload");
    c = n_eoc;
    idle(40);
    chk("single_quiet", c, n_eoc);
    // event counting: three falls end a count of two
    wr(TWU_OFF_CTRL, 8'hC8);
    c = n_eoc;
    fire(4'h2);
    chk("event_early", c, n_eoc);
    fire(4'h1);
    idle(4);
    chk("event_eoc", c + 1, n_eoc);
    // gated: counts only while the pin is high
    wr(TWU_OFF_CTRL, 8'h00);
    wr(TWU_OFF_CNT_LO, 8'h40);
    wr(TWU_OFF_CTRL, 8'h98);
    idle(20);
    rd_chk(TWU_OFF_CNT_LO, 8'h40, "gate_closed");
    idle_lvl <= 1'b1;
    idle(40);
    xfer(TWU_OFF_CNT_LO, 1'b0, 8'h00);
    chk("gate_open", 1, {31'h0, rd < 32'h40});
    // triggerable: waits for a fall after run
    idle_lvl <= 1'b0;
    wr(TWU_OFF_CTRL, 8'h00);
    wr(TWU_OFF_CNT_LO, 8'h40);
    wr(TWU_OFF_CTRL, 8'hA8);
    idle(20);
    rd_chk(TWU_OFF_CNT_LO, 8'h40, "trig_wait");
    fire(4'h1);
    idle(20);
    xfer(TWU_OFF_CNT_LO, 1'b0, 8'h00);
    chk("trig_run", 1, {31'h0, rd < 32'h40});
    // retriggerable: a fall reloads, but not while stopped
    wr(TWU_OFF_CTRL, 8'hB8);
    idle(40);
    fire(4'h1);
    xfer(TWU_OFF_CNT_LO, 1'b0, 8'h00);
    chk("retrig", 1, {31'h0, rd > 32'h3C});
    wr(TWU_OFF_CTRL, 8'h38);
    xfer(TWU_OFF_CNT_LO, 1'b0, 8'h00);
    p = rd;
    fire(4'h1);
    rd_chk(TWU_OFF_CNT_LO, p[7:0], "retrig_stopped");
    // software watchdog, kept alive by the key, then let expire
    wr(TWU_OFF_CNT_LO, 8'h07);
    wr(TWU_OFF_CTRL, 8'h00);
    wr(TWU_OFF_WDG, 8'h3F);
    c = n_sys;
    repeat (4)
    begin
      idle(10);
      wr(TWU_OFF_CNT_LO, TWU_KEY_FIRST);
      wr(TWU_OFF_CNT_LO, TWU_KEY_SECOND);
    end
    chk("kick", c, n_sys);
    wr(TWU_OFF_WDG, 8'h7F);
    rd_chk(TWU_OFF_WDG, TWU_WDG_FILL, "wdg_sticky");
    wr(TWU_OFF_CNT_HI, 8'h12);
    c = n_eoc;
    wait_ev(1, n);
    wait_ev(1, n);
    chk("wdg_period", 32, n);
    chk("wdg_no_irq", c, n_eoc);
    // hardware strap: watchdog on at reset, constant fixed
    strap <= 1'b0;
    reset <= 1'b1;
    idle(3);
    reset <= 1'b0;
    idle(2);
    wr(TWU_OFF_CNT_HI, 8'h00);
    rd_chk(TWU_OFF_CNT_HI, 8'hFF, "hw_const");
    xfer(TWU_OFF_STAT, 1'b0, 8'h00);
    chk("hw_active", 32'h6, rd & 32'h6);
    close_out();
  end
endmodule : twu_timer_watchdog_tb_top
